/* File: pkg/led_ctrl_pkg.sv */
/*
 * Shared constants for the LED drive, measurement and protection controller:
 * register offsets, field positions, reset values, timing counts, states.
 * Assumes a 250 MHz system clock and an 8-bit register port with 7-bit address.
 */
package led_ctrl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [6:0] ADDR_CODE_A_LO = 7'h01;
  localparam logic [6:0] ADDR_CODE_A_HI = 7'h02;
  localparam logic [6:0] ADDR_CODE_B_LO = 7'h03;
  localparam logic [6:0] ADDR_CODE_B_HI = 7'h04;
  localparam logic [6:0] ADDR_CODE_C_LO = 7'h05;
  localparam logic [6:0] ADDR_CODE_C_HI = 7'h06;
  localparam logic [6:0] ADDR_LIMIT_CFG = 7'h07;
  localparam logic [6:0] ADDR_MEAS_CFG = 7'h08;
  localparam logic [6:0] ADDR_UV_THRESH = 7'h09;
  localparam logic [6:0] ADDR_CTRL = 7'h0a;
  localparam logic [6:0] ADDR_MASK = 7'h0b;
  localparam logic [6:0] ADDR_INT_STATUS = 7'h0c;
  localparam logic [6:0] ADDR_PARK_TIME = 7'h0d;
  localparam logic [6:0] ADDR_STATE = 7'h0e;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int LIM_LEVEL_LSB = 0;
  localparam int LIM_EN_LSB = 4;
  localparam int MEAS_SEL_LSB = 0;
  localparam int MEAS_GAIN_LSB = 4;
  localparam int MEAS_CAL_BIT = 6;
  localparam int CTRL_MIRROR_BIT = 0;
  localparam int INT_HOT_BIT = 0;
  localparam int INT_TSD_BIT = 1;
  localparam int INT_BATLOW_BIT = 2;
  localparam int INT_UNDERVOLTAGE_LOCKOUT_FLAG_BIT = 3;

  ////////////////////////////////////////////////////////////////////////////
  // reset values and code limits
  localparam logic [9:0] CODE_RST = 10'h029;
  localparam logic [9:0] CODE_FULL = 10'h3ff;
  localparam logic [9:0] CODE_MIN = 10'h029;
  localparam logic [7:0] LIMIT_CFG_RST = 8'h00;
  localparam logic [7:0] MEAS_CFG_RST = 8'h00;
  localparam logic [4:0] UV_THRESH_RST = 5'h00;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [6:0] PARK_RST = 7'h64;
  localparam logic [3:0] MEAS_NO_CONNECT = 4'h8;
  localparam logic [3:0] MEAS_LAST = 4'h9;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int NS_PER_US = 1000;
  localparam int CYCLES_PER_US = NS_PER_US / CLK_PERIOD_NS;
  localparam logic [6:0] PARK_MAX_US = 7'h64;
  localparam int INT_REPOST_US = 32;
  localparam int INT_REPOST_CYCLES = INT_REPOST_US * CYCLES_PER_US;

  typedef enum logic [2:0] {S_OFF, S_STANDBY, S_ACTIVE, S_PARK, S_LOCKOUT} seq_state_t;

endpackage

/* File: hw/channel_select.sv */
/*
 * Strobe decode for the three channel switches: closes the selected switch,
 * applies its 10-bit current code and flags whether transient limiting applies.
 * Assumes led_select is synchronous to clk_sys.
 */
`timescale 1ns/10ps
module channel_select (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // selection and per-channel settings
  input wire logic [1:0] led_select,
  input wire logic [29:0] codes,
  input wire logic [2:0] limit_enable,
  // switch drive
  output logic [2:0] switch_close,
  output logic [9:0] current_code,
  output logic limit_active
);

  logic [2:0] hit;
  logic [9:0] part [0:2];
  wire [9:0] next_code = part[0] | part[1] | part[2];
  wire next_limit = |(hit & limit_enable);

  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_ch
      assign hit[i] = (led_select == 2'(i + 1));
      assign part[i] = hit[i] ? codes[i*10 +: 10] : 10'h000;
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      switch_close <= 3'h0;
      current_code <= 10'h000;
      limit_active <= 1'b0;
    end else begin
      switch_close <= hit;
      current_code <= next_code;
      limit_active <= next_limit;
    end
  end

  code_follow_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    led_select == 2'h2 |=> current_code == $past(codes[19:10]) && switch_close == 3'h2)
    else $error("selected channel code not applied");

endmodule

/* File: hw/fault_sequencer.sv */
/*
 * Power state sequencer: standby, active, thermal shutdown, undervoltage
 * lockout with mirror parking delay and fast discharge.
 * Assumes fault comparator inputs are synchronous to clk_sys.
 */
`timescale 1ns/10ps
module fault_sequencer #(
  parameter int STEP_CYCLES = led_ctrl_pkg::CYCLES_PER_US
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // controls
  input wire logic mirror_en,
  input wire logic [6:0] park_us,
  input wire logic power_request,
  // fault inputs
  input wire logic temp_shutdown,
  input wire logic undervoltage,
  input wire logic input_recovered,
  // results
  output logic rails_enable,
  output logic fast_discharge,
  output logic clear_mirror,
  output led_ctrl_pkg::seq_state_t state
);

  led_ctrl_pkg::seq_state_t next_state;
  logic [15:0] tick;
  logic [6:0] us_cnt;
  wire us_step = (tick == 16'(STEP_CYCLES - 1));
  wire park_done = (us_cnt >= park_us);

  always_comb begin
    next_state = state;
    case (state)
      led_ctrl_pkg::S_OFF: if (power_request && input_recovered) next_state = led_ctrl_pkg::S_STANDBY;
      led_ctrl_pkg::S_STANDBY:
        if (!power_request) next_state = led_ctrl_pkg::S_OFF;
        else if (undervoltage) next_state = led_ctrl_pkg::S_LOCKOUT;
        else if (mirror_en && !temp_shutdown) next_state = led_ctrl_pkg::S_ACTIVE;
      led_ctrl_pkg::S_ACTIVE:
        if (!power_request) next_state = led_ctrl_pkg::S_OFF;
        else if (undervoltage) next_state = led_ctrl_pkg::S_PARK;
        else if (temp_shutdown || !mirror_en) next_state = led_ctrl_pkg::S_STANDBY;
      led_ctrl_pkg::S_PARK: if (park_done) next_state = led_ctrl_pkg::S_LOCKOUT;
      led_ctrl_pkg::S_LOCKOUT: if (!power_request) next_state = led_ctrl_pkg::S_OFF;
      default: next_state = led_ctrl_pkg::S_OFF;
    endcase
  end

  wire next_rails = (next_state == led_ctrl_pkg::S_ACTIVE) || (next_state == led_ctrl_pkg::S_PARK);
  // host's enable is dropped on undervoltage, on thermal shutdown while active, and whenever the request is low
  wire next_clear = (next_state == led_ctrl_pkg::S_OFF) || (next_state == led_ctrl_pkg::S_PARK)
    || (next_state == led_ctrl_pkg::S_LOCKOUT) || (state == led_ctrl_pkg::S_ACTIVE && temp_shutdown);

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state <= led_ctrl_pkg::S_OFF;
      tick <= 16'h0000;
      us_cnt <= 7'h00;
      rails_enable <= 1'b0;
      fast_discharge <= 1'b0;
      clear_mirror <= 1'b0;
    end else begin
      state <= next_state;
      tick <= (state != led_ctrl_pkg::S_PARK || us_step) ? 16'h0000 : tick + 16'h0001;
      us_cnt <= (state != led_ctrl_pkg::S_PARK) ? 7'h00 : us_cnt + {6'h00, us_step};
      rails_enable <= next_rails;
      fast_discharge <= (next_state == led_ctrl_pkg::S_LOCKOUT);
      clear_mirror <= next_clear;
    end
  end

  tsd_rails_off_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    state == led_ctrl_pkg::S_ACTIVE && temp_shutdown && power_request && !undervoltage
    |=> !rails_enable && clear_mirror) else $error("rails stay on in thermal shutdown");

  park_before_dis_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(fast_discharge) && $past(state) == led_ctrl_pkg::S_PARK |-> $past(park_done))
    else $error("fast discharge before parking time ended");

  lockout_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    state == led_ctrl_pkg::S_LOCKOUT && power_request |=> state == led_ctrl_pkg::S_LOCKOUT
    && !rails_enable) else $error("lockout left without request toggle");

endmodule

/* File: hw/led_drive_measure_protection_ctrl.sv */
/*
 * Top of the LED drive, measurement and protection controller: register
 * port, per-channel current codes, transient limit, measurement mux settings,
 * interrupt status with open-drain pin, and the power sequencer.
 * Assumes one 250 MHz clock, synchronous active-low reset, and that all
 * analog comparator and pin inputs are already synchronous to clk_sys.
 */
// Function
// - separate 10-bit code per switch, selected applied
// - full-scale code gives max current, fixed steps
// - one transient limit level shared by all switches, 4-bit field
// - three enable bits choose limited switches
// - 4-bit select routes mux through gain
// - select codes map ten inputs, 8 unconnected
// - over warning temperature raises die-hot interrupt
// - shutdown temperature kills rails, sets flag
// - after shutdown, mirror stays off until rewrite
// - low battery raises interrupt, operation continues
// - lockout: interrupt, sequenced off, enable cleared
// - rails stay off until recovered and toggled
// - lockout threshold register, 31 steps programmable
// - park first, then fast discharge mirror rails
// - parking interval programmable up to 100 us
// - pin low on event, read clears, reasserts
// - mask gates pin only, flags still set
`timescale 1ns/10ps
module led_drive_measure_protection_ctrl #(
  parameter int STEP_CYCLES = led_ctrl_pkg::CYCLES_PER_US
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // register port
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // strobe selection
  input wire logic [1:0] led_select,
  // monitor inputs
  input wire logic temp_hot,
  input wire logic temp_shutdown,
  input wire logic battery_low,
  input wire logic undervoltage,
  input wire logic input_recovered,
  input wire logic system_power_request,
  // led drive
  output logic [2:0] switch_close,
  output logic [9:0] current_code,
  output logic [3:0] transient_limit_level,
  output logic limit_active,
  // measurement path
  output logic [3:0] meas_input_select,
  output logic [1:0] meas_gain_select,
  output logic meas_calibration_disable,
  // supplies
  output logic [4:0] undervoltage_level,
  output logic rails_enable,
  output logic fast_discharge,
  // interrupt pin, open drain
  input wire logic interrupt_out_n_in,
  output logic interrupt_out_n_drv,
  output logic interrupt_out_n_oe_n
);

  ////////////////////////////////////////////////////////////////////////////
  // register storage

  logic [9:0] code [0:2];
  logic [7:0] limit_cfg;
  logic [7:0] meas_cfg;
  logic [4:0] uv_thresh;
  logic mirror_en;
  logic [3:0] int_mask;
  logic [3:0] int_status;
  logic [6:0] park_us;
  logic clear_mirror;
  led_ctrl_pkg::seq_state_t seq_state;

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  wire wr_limit = reg_write && reg_addr == led_ctrl_pkg::ADDR_LIMIT_CFG;
  wire wr_meas = reg_write && reg_addr == led_ctrl_pkg::ADDR_MEAS_CFG;
  wire wr_uv = reg_write && reg_addr == led_ctrl_pkg::ADDR_UV_THRESH;
  wire wr_ctrl = reg_write && reg_addr == led_ctrl_pkg::ADDR_CTRL;
  wire wr_mask = reg_write && reg_addr == led_ctrl_pkg::ADDR_MASK;
  wire wr_park = reg_write && reg_addr == led_ctrl_pkg::ADDR_PARK_TIME;
  wire rd_int = reg_read && reg_addr == led_ctrl_pkg::ADDR_INT_STATUS;

  wire [6:0] code_lo_addr [0:2];
  assign code_lo_addr[0] = led_ctrl_pkg::ADDR_CODE_A_LO;
  assign code_lo_addr[1] = led_ctrl_pkg::ADDR_CODE_B_LO;
  assign code_lo_addr[2] = led_ctrl_pkg::ADDR_CODE_C_LO;

  // parking time beyond the supported maximum is held at the maximum
  wire [6:0] next_park = (reg_wdata[6:0] > led_ctrl_pkg::PARK_MAX_US)
    ? led_ctrl_pkg::PARK_MAX_US : reg_wdata[6:0];

  // an unconnected or undefined input select falls back to no connection
  wire [3:0] sel_field = meas_cfg[led_ctrl_pkg::MEAS_SEL_LSB +: 4];
  wire [3:0] next_sel = (sel_field > led_ctrl_pkg::MEAS_LAST)
    ? led_ctrl_pkg::MEAS_NO_CONNECT : sel_field;

  ////////////////////////////////////////////////////////////////////////////
  // current codes, one per channel switch

  wire [29:0] codes_flat = {code[2], code[1], code[0]};

  genvar ch;
  generate
    for (ch = 0; ch < 3; ch++) begin : g_code
      wire wr_lo = reg_write && reg_addr == code_lo_addr[ch];
      wire wr_hi = reg_write && reg_addr == code_lo_addr[ch] + 7'h01;
      always_ff @(posedge clk_sys) begin
        if (!rstn) begin
          code[ch] <= led_ctrl_pkg::CODE_RST;
        end else if (wr_lo) begin
          code[ch][7:0] <= reg_wdata;
        end else if (wr_hi) begin
          code[ch][9:8] <= reg_wdata[1:0];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      limit_cfg <= led_ctrl_pkg::LIMIT_CFG_RST;
      meas_cfg <= led_ctrl_pkg::MEAS_CFG_RST;
      uv_thresh <= led_ctrl_pkg::UV_THRESH_RST;
      int_mask <= led_ctrl_pkg::MASK_RST;
      park_us <= led_ctrl_pkg::PARK_RST;
    end else begin
      if (wr_limit) limit_cfg <= {1'b0, reg_wdata[6:0]};
      if (wr_meas) meas_cfg <= {1'b0, reg_wdata[6:0]};
      if (wr_uv) uv_thresh <= reg_wdata[4:0];
      if (wr_mask) int_mask <= reg_wdata[3:0];
      if (wr_park) park_us <= next_park;
    end
  end

  // a fault clear wins over a host write in the same cycle: rails must not
  // come back on the edge that took them down
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      mirror_en <= 1'b0;
    end else if (clear_mirror) begin
      mirror_en <= 1'b0;
    end else if (wr_ctrl) begin
      mirror_en <= reg_wdata[led_ctrl_pkg::CTRL_MIRROR_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // measurement and supply settings to the analog side

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      transient_limit_level <= 4'h0;
      meas_input_select <= led_ctrl_pkg::MEAS_NO_CONNECT;
      meas_gain_select <= 2'h0;
      meas_calibration_disable <= 1'b0;
      undervoltage_level <= led_ctrl_pkg::UV_THRESH_RST;
    end else begin
      transient_limit_level <= limit_cfg[led_ctrl_pkg::LIM_LEVEL_LSB +: 4];
      meas_input_select <= next_sel;
      meas_gain_select <= meas_cfg[led_ctrl_pkg::MEAS_GAIN_LSB +: 2];
      meas_calibration_disable <= meas_cfg[led_ctrl_pkg::MEAS_CAL_BIT];
      undervoltage_level <= uv_thresh;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status and open-drain pin

  wire [3:0] events;
  assign events[led_ctrl_pkg::INT_HOT_BIT] = temp_hot;
  assign events[led_ctrl_pkg::INT_TSD_BIT] = temp_shutdown;
  assign events[led_ctrl_pkg::INT_BATLOW_BIT] = battery_low;
  assign events[led_ctrl_pkg::INT_UNDERVOLTAGE_LOCKOUT_FLAG_BIT] = undervoltage;

  // set wins over the read clear; a lasting fault therefore re-posts on the
  // very next cycle, far inside the re-post bound
  wire [3:0] next_status = (rd_int ? 4'h0 : int_status) | events;
  // mask reaches the pin only, never the status bits
  wire pin_low = |(int_status & ~int_mask) && !rd_int;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      int_status <= 4'h0;
      interrupt_out_n_drv <= 1'b0;
      interrupt_out_n_oe_n <= 1'b1;
    end else begin
      int_status <= next_status;
      interrupt_out_n_drv <= 1'b0;
      interrupt_out_n_oe_n <= !pin_low;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read

  wire [7:0] state_word = {4'h0, interrupt_out_n_in, seq_state};
  logic [7:0] rd_mux;

  always_comb begin
    case (reg_addr)
      led_ctrl_pkg::ADDR_CODE_A_LO: rd_mux = code[0][7:0];
      led_ctrl_pkg::ADDR_CODE_A_HI: rd_mux = {6'h00, code[0][9:8]};
      led_ctrl_pkg::ADDR_CODE_B_LO: rd_mux = code[1][7:0];
      led_ctrl_pkg::ADDR_CODE_B_HI: rd_mux = {6'h00, code[1][9:8]};
      led_ctrl_pkg::ADDR_CODE_C_LO: rd_mux = code[2][7:0];
      led_ctrl_pkg::ADDR_CODE_C_HI: rd_mux = {6'h00, code[2][9:8]};
      led_ctrl_pkg::ADDR_LIMIT_CFG: rd_mux = limit_cfg;
      led_ctrl_pkg::ADDR_MEAS_CFG: rd_mux = meas_cfg;
      led_ctrl_pkg::ADDR_UV_THRESH: rd_mux = {3'h0, uv_thresh};
      led_ctrl_pkg::ADDR_CTRL: rd_mux = {7'h00, mirror_en};
      led_ctrl_pkg::ADDR_MASK: rd_mux = {4'h0, int_mask};
      led_ctrl_pkg::ADDR_INT_STATUS: rd_mux = {4'h0, int_status};
      led_ctrl_pkg::ADDR_PARK_TIME: rd_mux = {1'b0, park_us};
      led_ctrl_pkg::ADDR_STATE: rd_mux = state_word;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      reg_rdata <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel switches and power sequencing

  channel_select u_channel (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .led_select(led_select),
    .codes(codes_flat),
    .limit_enable(limit_cfg[led_ctrl_pkg::LIM_EN_LSB +: 3]),
    .switch_close(switch_close),
    .current_code(current_code),
    .limit_active(limit_active)
  );

  fault_sequencer #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_seq (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .mirror_en(mirror_en),
    .park_us(park_us),
    .power_request(system_power_request),
    .temp_shutdown(temp_shutdown),
    .undervoltage(undervoltage),
    .input_recovered(input_recovered),
    .rails_enable(rails_enable),
    .fast_discharge(fast_discharge),
    .clear_mirror(clear_mirror),
    .state(seq_state)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  hot_no_rail_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    temp_hot && !temp_shutdown && !undervoltage && rails_enable && mirror_en
    && system_power_request && seq_state == led_ctrl_pkg::S_ACTIVE
    |=> rails_enable && int_status[led_ctrl_pkg::INT_HOT_BIT])
    else $error("die-hot warning disturbed the rails");

  batlow_flag_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    battery_low |=> int_status[led_ctrl_pkg::INT_BATLOW_BIT])
    else $error("battery-low event not flagged");

  undervoltage_lockout_flag_clears_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    undervoltage && seq_state == led_ctrl_pkg::S_ACTIVE && system_power_request
    |=> ##1 !mirror_en) else $error("lockout left mirror enable set");

  read_release_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    rd_int |=> interrupt_out_n_oe_n) else $error("pin not released on status read");

  mask_pin_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (int_status & ~int_mask) == 4'h0 |=> interrupt_out_n_oe_n)
    else $error("masked event pulled the pin");

  park_limit_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_park |=> park_us <= led_ctrl_pkg::PARK_MAX_US && park_us == $past(next_park))
    else $error("parking time outside range");

  mux_select_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    sel_field > led_ctrl_pkg::MEAS_LAST |=> meas_input_select == led_ctrl_pkg::MEAS_NO_CONNECT)
    else $error("undefined input select reached the mux");

  tsd_flag_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    temp_shutdown |=> int_status[led_ctrl_pkg::INT_TSD_BIT])
    else $error("thermal shutdown not flagged");

  undervoltage_lockout_flag_flag_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    undervoltage |=> int_status[led_ctrl_pkg::INT_UNDERVOLTAGE_LOCKOUT_FLAG_BIT])
    else $error("lockout event not flagged");

  fault_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    clear_mirror |=> !mirror_en) else $error("host write beat the fault clear");

  // the re-post bound is thousands of cycles, so it is counted here
  // rather than unrolled in a property
  logic [15:0] repost_wait;

  always_ff @(posedge clk_sys) begin
    if (!rstn || !interrupt_out_n_oe_n || (events & ~int_mask) == 4'h0) begin
      repost_wait <= 16'h0000;
    end else begin
      repost_wait <= repost_wait + 16'h0001;
    end
  end

  repost_bound_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    repost_wait < 16'(led_ctrl_pkg::INT_REPOST_CYCLES))
    else $error("persistent fault not posted again on the pin");

endmodule

/* File: tb/host_model.sv */
/*
 * Host controller model: register writes and reads, power request pin.
 * Assumes one caller process and the 250 MHz clk_sys of the block.
 */
`timescale 1ns/10ps
module host_model (
  // clock
  input wire logic clk_sys,
  // register port
  output logic [6:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_write,
  output logic reg_read,
  input wire logic [7:0] reg_rdata,
  // power request pin
  output logic system_power_request
);
  initial begin
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    system_power_request = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // callers keep codes >= minimum and pick gain, cal bit, limit
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
    // released bus shows junk, not the last value
    reg_wdata <= ~d;
    reg_addr <= ~a;
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask

  // toggled low then high to restart after lockout
  task automatic power(input logic v);
    @(posedge clk_sys);
    system_power_request <= v;
  endtask
endmodule

/* File: tb/led_drive_measure_protection_ctrl_test.sv */
/*
 * Self-checking bench for the LED drive, measurement and protection block.
 * Assumes STEP_CYCLES of 4 so a microsecond of parking is 4 cycles.
 */
`timescale 1ns/10ps
module led_drive_measure_protection_ctrl_test;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic reg_write, reg_read, system_power_request;
  logic [1:0] led_select = 2'h0;
  logic temp_hot = 1'b0, temp_shutdown = 1'b0, battery_low = 1'b0, undervoltage = 1'b0;
  logic input_recovered = 1'b1;
  logic [2:0] switch_close;
  logic [9:0] current_code;
  logic [9:0] code [3];
  logic [3:0] lim_level, meas_sel;
  logic [1:0] meas_gain;
  logic [4:0] uv_level, t;
  logic [6:0] lim, m;
  logic limit_active, meas_cal, rails_enable, fast_discharge, pin_drv, pin_oe_n;
  wire logic pin_level = pin_oe_n ? 1'b1 : pin_drv;
  int n_fail = 0, compares = 0, cycles = 0;
  logic [31:0] seed = 32'h7;

  always #2 clk_sys = ~clk_sys;

  host_model u_host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .system_power_request(system_power_request));

  led_drive_measure_protection_ctrl #(.STEP_CYCLES(4)) u_dut (.clk_sys(clk_sys),
    .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .led_select(led_select),
    .temp_hot(temp_hot), .temp_shutdown(temp_shutdown), .battery_low(battery_low),
    .undervoltage(undervoltage), .input_recovered(input_recovered),
    .system_power_request(system_power_request), .switch_close(switch_close),
    .current_code(current_code), .transient_limit_level(lim_level),
    .limit_active(limit_active), .meas_input_select(meas_sel),
    .meas_gain_select(meas_gain), .meas_calibration_disable(meas_cal),
    .undervoltage_level(uv_level), .rails_enable(rails_enable),
    .fast_discharge(fast_discharge), .interrupt_out_n_in(pin_level),
    .interrupt_out_n_drv(pin_drv), .interrupt_out_n_oe_n(pin_oe_n));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [3:0] exp_sel(input logic [3:0] s);
    return (s > 4'h9) ? 4'h8 : s;
  endfunction

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // bounded wait; a stuck output shows as a mismatch, not a hang
  task automatic wait_until(input string what, ref logic sig, input logic v);
    for (int i = 0; i < 64 && sig !== v; i++) @(posedge clk_sys);
    #1;
    chk(what, sig, v);
  endtask

  // one-cycle event on battery_low (bat set) or temp_hot
  task automatic pulse(input bit bat);
    @(posedge clk_sys);
    if (bat) battery_low <= 1'b1;
    else temp_hot <= 1'b1;
    @(posedge clk_sys);
    battery_low <= 1'b0;
    temp_hot <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    u_host.rd(7'h02, d);
    chk("code hi reset", d, 8'h00);
    u_host.rd(7'h7f, d);
    chk("unmapped", d, 8'h00);
    for (int k = 0; k < 3; k++) begin
      code[k] = (k == 2) ? 10'h3ff : 10'h029 + 10'(rnd() % 983);
      u_host.wr(7'(2 * k + 1), code[k][7:0]);
      u_host.wr(7'(2 * k + 2), {6'h00, code[k][9:8]});
    end
    lim = 7'(rnd());
    u_host.wr(7'h07, {1'b0, lim});
    for (int s = 0; s < 4; s++) begin
      @(posedge clk_sys);
      led_select <= 2'(s);
      repeat (2) @(posedge clk_sys);
      #1;
      chk("close", switch_close, (s == 0) ? 3'h0 : 3'h1 << (s - 1));
      chk("code", current_code, (s == 0) ? 10'h0 : code[s - 1]);
      chk("limited", limit_active, (s == 0) ? 1'b0 : lim[3 + s]);
    end
    chk("limit level", lim_level, lim[3:0]);
    for (int s = 0; s < 16; s++) begin
      m = {1'(rnd()), (s == 4) ? 2'h3 : (s > 4 && s < 8) ? 2'h2 : 2'h1, 4'(s)};
      u_host.wr(7'h08, {1'b0, m});
      repeat (2) @(posedge clk_sys);
      #1;
      chk("meas sel", meas_sel, exp_sel(m[3:0]));
      chk("meas gain", {meas_cal, meas_gain}, m[6:4]);
    end
    for (int i = 0; i < 3; i++) begin
      t = (i == 0) ? 5'h1f : (i == 1) ? 5'h00 : 5'(rnd());
      u_host.wr(7'h09, {3'h0, t});
      u_host.rd(7'h09, d);
      chk("uv thresh", d, {3'h0, t});
      chk("uv level", uv_level, t);
    end
    u_host.wr(7'h0d, 8'h7f);
    u_host.rd(7'h0d, d);
    chk("park clamp", d, 8'h64);
    u_host.wr(7'h0d, 8'h02);
    u_host.wr(7'h0b, 8'h00);
    pulse(1'b0);
    chk("pin hot", pin_level, 1'b0);
    u_host.rd(7'h0c, d);
    chk("status hot", d, 8'h01);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("pin released", pin_level, 1'b1);
    u_host.wr(7'h0b, 8'h04);
    pulse(1'b1);
    chk("pin masked", pin_level, 1'b1);
    u_host.rd(7'h0c, d);
    chk("status batlow", d, 8'h04);
    @(posedge clk_sys) temp_hot <= 1'b1;
    u_host.rd(7'h0c, d);
    wait_until("pin again", pin_oe_n, 1'b0);
    @(posedge clk_sys) temp_hot <= 1'b0;
    u_host.rd(7'h0c, d);
    u_host.power(1'b1);
    u_host.wr(7'h0a, 8'h01);
    wait_until("rails on", rails_enable, 1'b1);
    @(posedge clk_sys) undervoltage <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    chk("parking", {rails_enable, fast_discharge}, 2'b10);
    wait_until("discharge", fast_discharge, 1'b1);
    chk("rails off", rails_enable, 1'b0);
    u_host.rd(7'h0a, d);
    chk("enable cleared", d, 8'h00);
    u_host.rd(7'h0c, d);
    chk("status undervoltage_lockout_flag", d[3], 1'b1);
    @(posedge clk_sys) undervoltage <= 1'b0;
    input_recovered <= 1'b0;
    u_host.power(1'b0);
    u_host.power(1'b1);
    u_host.wr(7'h0a, 8'h01);
    repeat (10) @(posedge clk_sys);
    #1;
    chk("held off", rails_enable, 1'b0);
    @(posedge clk_sys) input_recovered <= 1'b1;
    u_host.wr(7'h0a, 8'h01);
    wait_until("restart", rails_enable, 1'b1);
    @(posedge clk_sys) temp_shutdown <= 1'b1;
    wait_until("tsd off", rails_enable, 1'b0);
    u_host.rd(7'h0c, d);
    chk("status tsd", d[1], 1'b1);
    @(posedge clk_sys) temp_shutdown <= 1'b0;
    u_host.rd(7'h0a, d);
    chk("mirror stays off", {d[0], rails_enable}, 2'b00);
    u_host.wr(7'h0a, 8'h01);
    wait_until("mirror back", rails_enable, 1'b1);
    tally_and_finish();
  end
endmodule
